// File: design/crypt_pkg.sv
package crypt_pkg;

    // ----------------------------------------------------------------
    // Register map, field positions and reset values
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 32;
    localparam int          BLOCK_W    = 128;
    localparam logic [15:0] KEY_OFS    = 16'hffa0;
    localparam logic [15:0] BLOCK_OFS  = 16'hffb0;
    localparam logic [15:0] CTRL_OFS   = 16'hffc0;
    localparam int          DIR_BIT    = 0;
    localparam int          START_BIT  = 1;
    localparam int          READY_BIT  = 2;
    localparam int          REINIT_BIT = 4;
    localparam logic [7:0]  CTRL_RESET = 8'h04;
    localparam logic [3:0]  NUM_ROUNDS = 4'h0a;
    localparam logic [3:0]  ROUND_ONE  = 4'h1;

    // Control register fields, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] rsv_hi;
        logic       reinit;
        logic       rsv_mid;
        logic       ready;
        logic       start;
        logic       dir;
    } ctrl_type;

    typedef enum logic [1:0] {ST_IDLE, ST_EXPAND, ST_ROUND} phase_type;

    // ----------------------------------------------------------------
    // Field arithmetic shared by the engine and the register file
    // ----------------------------------------------------------------
    function automatic logic [7:0] xtime(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    endfunction

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h00;
        p = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i]) r = r ^ p;
            p = xtime(p);
        end
        return r;
    endfunction

    // Inverse as a^254; a table would cost far more source
    function automatic logic [7:0] gf_inv(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h01;
        p = a;
        for (int i = 1; i < 8; i++)
        begin
            p = gf_mul(p, p);
            r = gf_mul(r, p);
        end
        return r;
    endfunction

    function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
        logic [15:0] t;
        t = {a, a} << n;
        return t[15:8];
    endfunction

    function automatic logic [7:0] sbox_fwd(input logic [7:0] x);
        logic [7:0] y;
        y = gf_inv(x);
        return y ^ rotl(y, 1) ^ rotl(y, 2) ^ rotl(y, 3) ^ rotl(y, 4) ^ 8'h63;
    endfunction

    function automatic logic [7:0] sbox_inv(input logic [7:0] x);
        return gf_inv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6) ^ 8'h05);
    endfunction

    function automatic logic [7:0] rcon(input logic [3:0] idx);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 1; i < 10; i++)
            if (i < idx) r = xtime(r);
        return r;
    endfunction

    // Lane j of word w holds byte 4w+j counted from the MSB end
    function automatic logic [31:0] get_word(input logic [127:0] v, input logic [1:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int j = 0; j < 4; j++)
            r[8*j +: 8] = v[127 - 32*w - 8*j -: 8];
        return r;
    endfunction

    function automatic logic [127:0] put_word(input logic [127:0] v, input logic [1:0] w,
                                              input logic [31:0] d, input logic [3:0] s);
        logic [127:0] r;
        r = v;
        for (int j = 0; j < 4; j++)
            if (s[j]) r[127 - 32*w - 8*j -: 8] = d[8*j +: 8];
        return r;
    endfunction

endpackage

// File: design/crypt_keystep.sv
`timescale 1ns/1ns
module crypt_keystep
    import crypt_pkg::*;
(
    input  wire logic [127:0] rk_in,    // Current round key
    input  wire logic [7:0]   rc,       // Round constant of the later key
    input  wire logic         inverse,  // High steps one key backward
    output wire logic [127:0] rk_out    // Neighbouring round key
);
    // ----------------------------------------------------------------
    // One expansion step, forward or undone
    // ----------------------------------------------------------------
    wire logic [31:0] w0 = rk_in[127:96];
    wire logic [31:0] w1 = rk_in[95:64];
    wire logic [31:0] w2 = rk_in[63:32];
    wire logic [31:0] w3 = rk_in[31:0];
    wire logic [31:0] p3 = w3 ^ w2;
    wire logic [31:0] gi = inverse ? p3 : w3;
    wire logic [31:0] g  = {sbox_fwd(gi[23:16]) ^ rc, sbox_fwd(gi[15:8]),
                            sbox_fwd(gi[7:0]), sbox_fwd(gi[31:24])};
    wire logic [31:0] n0 = w0 ^ g;
    wire logic [31:0] n1 = w1 ^ n0;
    wire logic [31:0] n2 = w2 ^ n1;

    // Backward step rebuilds the older words from the newer ones
    assign rk_out = inverse ? {w0 ^ g, w1 ^ w0, w2 ^ w1, p3} : {n0, n1, n2, w3 ^ n2};
endmodule

// File: design/crypt_round.sv
`timescale 1ns/1ns
module crypt_round
    import crypt_pkg::*;
(
    input  wire logic [127:0] st_in,    // State entering the round
    input  wire logic [127:0] rk,       // Round key
    input  wire logic         decrypt,  // High runs the inverse round
    input  wire logic         last,     // High skips column mixing
    output logic      [127:0] st_out    // State leaving the round
);
    // ----------------------------------------------------------------
    // Byte 4c+r is row r of column c
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] a [16];
        logic [7:0] t [16];
        logic [7:0] cf [4];
        for (int i = 0; i < 16; i++) a[i] = st_in[127 - 8*i -: 8];
        t = '{default: 8'h00};
        if (decrypt)
            cf = '{8'h0e, 8'h0b, 8'h0d, 8'h09};
        else
            cf = '{8'h02, 8'h03, 8'h01, 8'h01};
        // Shift rows and substitute; decrypt adds its key before mixing
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                t[4*c + r] = decrypt ? sbox_inv(a[4*((c + 4 - r) % 4) + r]) ^ rk[127 - 32*c - 8*r -: 8]
                                     : sbox_fwd(a[4*((c + r) % 4) + r]);
        st_out = '0;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
            begin
                st_out[127 - 32*c - 8*r -: 8] = last ? t[4*c + r] : 8'h00;
                if (!last)
                    for (int k = 0; k < 4; k++)
                        st_out[127 - 32*c - 8*r -: 8] ^= gf_mul(cf[(k + 4 - r) % 4], t[4*c + k]);
            end
        if (!decrypt) st_out = st_out ^ rk;
    end
endmodule

// File: design/block_direction_select_coprocessor.sv
`timescale 1ns/1ns
module block_direction_select_coprocessor
    import crypt_pkg::*;
(
    input  wire logic              pclk,     // Bus clock, 25 MHz
    input  wire logic              presetn,  // Async reset, active low
    input  wire logic              psel,     // Slave select
    input  wire logic              penable,  // Access phase
    input  wire logic              pwrite,   // High for write
    input  wire logic [ADDR_W-1:0] paddr,    // Byte address
    input  wire logic [DATA_W-1:0] pwdata,   // Write data
    input  wire logic [3:0]        pstrb,    // Byte lane strobes
    output logic      [DATA_W-1:0] prdata,   // Read data
    output logic                   pready,   // Transfer done
    output logic                   pslverr   // Unmapped address
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [BLOCK_W-1:0] key_q;
    logic [BLOCK_W-1:0] key_d;
    logic [BLOCK_W-1:0] block_q;
    logic [BLOCK_W-1:0] block_d;
    logic [BLOCK_W-1:0] st_q;
    logic [BLOCK_W-1:0] st_d;
    logic [BLOCK_W-1:0] rk_q;
    logic [BLOCK_W-1:0] rk_d;
    ctrl_type           ctrl_q;
    ctrl_type           ctrl_d;
    phase_type          phase_q;
    phase_type          phase_d;
    logic [3:0]         rnd_q;
    logic [3:0]         rnd_d;
    logic [DATA_W-1:0]  prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [BLOCK_W-1:0] ks_out;
    logic [BLOCK_W-1:0] rnd_out;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // First access cycle answers with a wait state; second completes
    wire logic      setup_acc = psel & penable & ~pready_q;
    wire logic      done_acc  = psel & penable & pready_q;
    wire logic      key_hit   = paddr[15:4] == KEY_OFS[15:4];
    wire logic      blk_hit   = paddr[15:4] == BLOCK_OFS[15:4];
    wire logic      ctrl_hit  = paddr[15:2] == CTRL_OFS[15:2];
    wire logic      map_hit   = key_hit | blk_hit | ctrl_hit;
    wire logic [1:0] widx     = paddr[3:2];
    wire logic      busy      = phase_q != ST_IDLE;
    wire ctrl_type  wctrl     = ctrl_type'(pwdata[7:0]);

    // Operands are frozen while the engine runs, so late writes drop
    wire logic wr_key  = done_acc & pwrite & key_hit & ~busy;
    wire logic wr_blk  = done_acc & pwrite & blk_hit & ~busy;
    wire logic wr_ctrl = done_acc & pwrite & ctrl_hit & pstrb[0];
    wire logic start_req = wr_ctrl & wctrl.start & ~wctrl.reinit & ~ctrl_q.reinit & ~busy;

    // Read view; reserved control bits stay zero
    wire logic [7:0] ctrl_view = {3'b000, ctrl_q.reinit, 1'b0, ctrl_q.ready, ctrl_q.start, ctrl_q.dir};
    wire logic [DATA_W-1:0] rd_word = key_hit  ? get_word(key_q, widx) :
                                      blk_hit  ? get_word(block_q, widx) :
                                      ctrl_hit ? {24'h00_0000, ctrl_view} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Engine sequencing
    // ----------------------------------------------------------------
    wire logic launch = (phase_q == ST_IDLE) & ctrl_q.start & ~ctrl_q.reinit;
    wire logic last   = ctrl_q.dir ? (rnd_q == NUM_ROUNDS) : (rnd_q == ROUND_ONE);
    wire logic finish = (phase_q == ST_ROUND) & last & ~ctrl_q.reinit;

    // Decrypt walks the schedule backward after expanding to the end
    crypt_keystep u_keystep (
        .rk_in   (rk_q),
        .rc      (rcon(rnd_q)),
        .inverse ((phase_q == ST_ROUND) & ~ctrl_q.dir),
        .rk_out  (ks_out)
    );

    crypt_round u_round (
        .st_in   (st_q),
        .rk      (ks_out),
        .decrypt (~ctrl_q.dir),
        .last    (last),
        .st_out  (rnd_out)
    );

    // Round sequence; one round per clock
    always_comb
    begin
        phase_d = phase_q;
        rnd_d   = rnd_q;
        st_d    = st_q;
        rk_d    = rk_q;
        key_d   = wr_key ? put_word(key_q, widx, pwdata, pstrb) : key_q;
        block_d = wr_blk ? put_word(block_q, widx, pwdata, pstrb) : block_q;
        unique case (phase_q)
            ST_IDLE:
            begin
                if (launch)
                begin
                    rk_d    = key_q;
                    rnd_d   = ROUND_ONE;
                    st_d    = block_q ^ key_q;
                    phase_d = ctrl_q.dir ? ST_ROUND : ST_EXPAND;
                end
            end
            ST_EXPAND:
            begin
                rk_d = ks_out;
                if (rnd_q == NUM_ROUNDS)
                begin
                    st_d    = block_q ^ ks_out;
                    phase_d = ST_ROUND;
                end
                else
                    rnd_d = rnd_q + 4'h1;
            end
            ST_ROUND:
            begin
                rk_d  = ks_out;
                st_d  = rnd_out;
                rnd_d = ctrl_q.dir ? rnd_q + 4'h1 : rnd_q - 4'h1;
                // A reinit in the last round leaves the block untouched
                if (finish)
                begin
                    block_d = rnd_out;
                    phase_d = ST_IDLE;
                end
            end
        endcase
        if (ctrl_q.reinit) phase_d = ST_IDLE;
    end

    // Control bits; a start request wins over the self clear
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d.reinit = wctrl.reinit;
            if (!busy) ctrl_d.dir = wctrl.dir;
        end
        if (ctrl_q.reinit)
        begin
            ctrl_d.start = 1'b0;
            ctrl_d.ready = 1'b1;
        end
        // Launch, the cycle after a start request, clears start and keeps ready low
        if (launch)
        begin
            ctrl_d.start = 1'b0;
            ctrl_d.ready = 1'b0;
        end
        if (start_req)
        begin
            ctrl_d.start = 1'b1;
            ctrl_d.ready = 1'b0;
        end
        if (finish) ctrl_d.ready = 1'b1;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_q   <= '0;
            block_q <= '0;
            st_q    <= '0;
            rk_q    <= '0;
            ctrl_q  <= ctrl_type'(CTRL_RESET);
            phase_q <= ST_IDLE;
            rnd_q   <= ROUND_ONE;
        end
        else
        begin
            key_q   <= key_d;
            block_q <= block_d;
            st_q    <= st_d;
            rk_q    <= rk_d;
            ctrl_q  <= ctrl_d;
            phase_q <= phase_d;
            rnd_q   <= rnd_d;
        end
    end

    // Bus answer; read data is captured one cycle before completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup_acc;
            pslverr_q <= setup_acc & ~map_hit;
            if (setup_acc) prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    key_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> $stable(key_q))
        else $error("key changed during an operation");

    byte_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_acc && !pwrite && key_hit && widx == 2'b00 |=> prdata_q[7:0] == $past(key_q[127:120]))
        else $error("key MSB not on lowest byte lane");

    result_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> block_q == $past(rnd_out) && !busy)
        else $error("result not left in block register");

    round_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |-> rnd_q >= ROUND_ONE && rnd_q <= NUM_ROUNDS)
        else $error("round counter out of range");

    reinit_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.reinit |=> phase_q == ST_IDLE && ctrl_q.ready && !ctrl_q.start)
        else $error("reinit did not idle the engine");

    ready_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |-> !ctrl_q.ready)
        else $error("ready high while busy");

    start_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        launch && !start_req |=> !ctrl_q.start ##0 busy)
        else $error("start bit not cleared at launch");

    dir_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        launch |=> phase_q == ($past(ctrl_q.dir) ? ST_ROUND : ST_EXPAND))
        else $error("wrong operation for direction bit");

    enc_time_a: assert property (@(posedge pclk) disable iff (!presetn || ctrl_q.reinit)
        launch && ctrl_q.dir |=> !ctrl_q.ready [*8] ##3 ctrl_q.ready)
        else $error("encryption not done in ten rounds");

    dec_time_a: assert property (@(posedge pclk) disable iff (!presetn || ctrl_q.reinit)
        launch && !ctrl_q.dir |=> !ctrl_q.ready [*8] ##13 ctrl_q.ready)
        else $error("decryption not done in twenty cycles");

    ready_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_req |=> !ctrl_q.ready && ctrl_q.start)
        else $error("ready did not fall on start");

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_acc |=> pready_q && pslverr_q == !$past(map_hit))
        else $error("bus answer late or wrong");

    blk_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy && !finish |=> $stable(block_q))
        else $error("block changed during an operation");

    bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_acc && pwrite && !map_hit && !finish |=> $stable(key_q) && $stable(block_q))
        else $error("unmapped write changed a register");

    rnd_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) |-> rnd_q == ROUND_ONE)
        else $error("operation did not start at round one");

    reinit_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && wctrl.reinit |=> ctrl_q.reinit)
        else $error("reinit bit not taken");

    ready_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> ctrl_q.ready && !busy)
        else $error("ready not raised at completion");

    launch_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) |-> $past(ctrl_q.start) && !$past(ctrl_q.reinit))
        else $error("engine ran without a start");

    dir_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> $stable(ctrl_q.dir))
        else $error("direction changed during an operation");

    expand_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
        phase_q == ST_EXPAND |-> !ctrl_q.dir)
        else $error("key expansion run for encryption");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q)
        else $error("pready held longer than one cycle");

    err_pready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr_q |-> pready_q)
        else $error("error without pready");

    unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_acc && !map_hit |=> prdata_q == 32'h0000_0000)
        else $error("unmapped read data not zero");
endmodule

// File: verif/block_direction_select_coprocessor_bench.sv
`timescale 1ns/1ns
module block_direction_select_coprocessor_bench
    import crypt_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus signals and known-answer vectors
    // ----------------------------------------------------------------
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    int                error_cnt;
    int                samples_checked;

    localparam logic [127:0] KAT_KEY = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
    localparam logic [127:0] KAT_PT  = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    localparam logic [127:0] KAT_CT  = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;

    block_direction_select_coprocessor DUT (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    // 25 MHz bus clock
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Bus and comparison tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; an idle cycle follows so the next setup never lands in this time step
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle limit here; a lost pready is left to the watchdog
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, 4'hf, r, e);
        chk("write pslverr", 128'h0, {127'h0, e});
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, 4'hf, r, e);
        chk("read pslverr", 128'h0, {127'h0, e});
    endtask

    // Lane j of word w carries byte 4w+j counted from the most significant end
    function automatic logic [31:0] word_of(input logic [127:0] v, input int w);
        logic [31:0] r;
        for (int j = 0; j < 4; j++)
            r[8*j +: 8] = v[127 - 32*w - 8*j -: 8];
        return r;
    endfunction

    task automatic wr128(input logic [15:0] a, input logic [127:0] v);
        for (int w = 0; w < 4; w++)
            wr(a + 16'(4*w), word_of(v, w));
    endtask

    task automatic chk128(input string what, input logic [15:0] a, input logic [127:0] exp);
        logic [31:0] r;
        for (int w = 0; w < 4; w++)
        begin
            rd(a + 16'(4*w), r);
            chk(what, 128'(word_of(exp, w)), 128'(r));
        end
    endtask

    // Launch one operation, see it busy, then poll ready under a bounded count
    task automatic run(input logic dir);
        logic [31:0] r;
        int          n;
        n = 0;
        wr(CTRL_OFS, {30'h0, 1'b1, dir});
        rd(CTRL_OFS, r);
        chk("ctrl ready and start while busy", 128'h0, 128'(r[2:1]));
        do
        begin
            rd(CTRL_OFS, r);
            n++;
        end
        while (r[READY_BIT] !== 1'b1 && n < 40);
        chk("ready after run", 128'h1, 128'(r[READY_BIT]));
        chk("direction kept", {127'h0, dir}, 128'(r[DIR_BIT]));
    endtask

    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0]  r;
        logic         e;
        logic [127:0] k;
        logic [127:0] p;
        logic [127:0] x;
        error_cnt = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(32'h997905b1));
        rd(CTRL_OFS, r);
        chk("ctrl reset value", 128'h04, 128'(r));
        chk128("key reset value", KEY_OFS, 128'h0);
        chk128("block reset value", BLOCK_OFS, 128'h0);
        // Known answer both ways checks byte order as well as the direction_select itself
        wr128(KEY_OFS, KAT_KEY);
        wr128(BLOCK_OFS, KAT_PT);
        chk128("key readback", KEY_OFS, KAT_KEY);
        run(1'b1);
        chk128("direction_select result", BLOCK_OFS, KAT_CT);
        run(1'b0);
        chk128("plain result", BLOCK_OFS, KAT_PT);
        // Single lane write touches byte 13 only
        apb(1'b1, BLOCK_OFS + 16'h000c, 32'h5a5a_5a5a, 4'b0010, r, e);
        x = KAT_PT;
        x[23:16] = 8'h5a;
        chk128("strobed block", BLOCK_OFS, x);
        // Unmapped addresses answer with an error and read zero
        apb(1'b0, 16'hffd0, 32'h0000_0000, 4'hf, r, e);
        chk("unmapped read error", 128'h1, 128'(e));
        chk("unmapped read data", 128'h0, 128'(r));
        apb(1'b1, 16'hffc8, 32'hffff_ffff, 4'hf, r, e);
        chk("unmapped write error", 128'h1, 128'(e));
        // Reinit in mid-run aborts, and refuses a start while held
        wr128(BLOCK_OFS, KAT_PT);
        wr(CTRL_OFS, 32'h0000_0003);
        wr(CTRL_OFS, 32'h0000_0010);
        rd(CTRL_OFS, r);
        chk("ctrl after reinit", 128'h2, 128'(r[2:1]));
        wr(CTRL_OFS, 32'h0000_0013);
        rd(CTRL_OFS, r);
        chk("start under reinit", 128'h2, 128'(r[2:1]));
        wr(CTRL_OFS, 32'h0000_0000);
        wr128(BLOCK_OFS, KAT_PT);
        run(1'b1);
        chk128("direction_select after reinit", BLOCK_OFS, KAT_CT);
        // Random round trips, the first with an all-ones corner
        for (int i = 0; i < 6; i++)
        begin
            k = {$urandom, $urandom, $urandom, $urandom};
            p = {$urandom, $urandom, $urandom, $urandom};
            if (i == 0)
            begin
                k = '1;
                p = '1;
            end
            wr128(KEY_OFS, k);
            wr128(BLOCK_OFS, p);
            run(1'b1);
            run(1'b0);
            chk128("round trip", BLOCK_OFS, p);
        end
        conclude;
    end

    // Watchdog: the whole sequence needs under a thousand cycles
    initial
    begin
        #(40 * 50000);
        error_cnt++;
        $display("mismatch watchdog expected finish seen timeout");
        conclude;
    end

endmodule
